// ---- rtl/psnp_regs.sv ----
// status summary and next page transmit register bank
`timescale 1ns/1ps
// Behaviour
// - comply-acknowledge bit is software writable, resets to 0, sent in next page
// - sent toggle is read-only, resets 0, inverse of last exchanged word toggle
// - 11-bit code field writable, resets to null page 000 0000 0001
// - message flag set sends code as message page, else unformatted page
// - top two summary bits ignore writes and read as zero
// - receive error latches high until receive error counter register read
// - polarity copy in summary clears on tenbase status read only
// - false carrier latches high until false carrier counter register read
// - signal detect is latched-low read-only, resets to 0
// - descrambler lock is latched-low read-only, resets to 0
// - page received copy survives summary read, clears on expansion read
// - expansion page received sets on word arrival, clears on its read
// - false carrier count 8 bits, saturates at ff, clears on read

module psnp_regs
  import psnp_pkg::*;
(
  input wire logic clk, // core clock, 25 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire psnp_bus_s bus, // register port request
  output logic [15:0] rdata, // read data, cycle after the read strobe
  input wire psnp_evt_s ev, // receive and negotiation events
  output psnp_np_s np_word, // next page fields to the transmitter
  output logic irq // level interrupt, unmasked status set
);

  // ---------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------
  logic hit_exp, hit_npt, hit_sum, hit_fcc, hit_rec, hit_ten;
  logic hit_ist, hit_imk;
  logic rd_exp, rd_sum, rd_fcc, rd_rec, rd_ten;
  logic wr_npt, wr_fcc, wr_ist, wr_imk;

  // one compare per register, qualified by the strobes below
  assign hit_exp = (bus.addr == OFS_AUTONEG_EXPANSION);
  assign hit_npt = (bus.addr == OFS_NEXT_PAGE_TRANSMIT);
  assign hit_sum = (bus.addr == OFS_PHY_STATUS_SUMMARY);
  assign hit_fcc = (bus.addr == OFS_FALSE_CARRIER_CNT);
  assign hit_rec = (bus.addr == OFS_RECEIVE_ERROR_CNT);
  assign hit_ten = (bus.addr == OFS_TENBASE_STATUS);
  assign hit_ist = (bus.addr == OFS_IRQ_STATUS);
  assign hit_imk = (bus.addr == OFS_IRQ_MASK);

  // read side effects fire only on a real read
  assign rd_exp = bus.rd & hit_exp;
  assign rd_sum = bus.rd & hit_sum;
  assign rd_fcc = bus.rd & hit_fcc;
  assign rd_rec = bus.rd & hit_rec;
  assign rd_ten = bus.rd & hit_ten;
  assign wr_npt = bus.wr & hit_npt;
  assign wr_fcc = bus.wr & hit_fcc;
  assign wr_ist = bus.wr & hit_ist;
  assign wr_imk = bus.wr & hit_imk;

  // ---------------------------------------------------------------------
  // next page transmit register
  // ---------------------------------------------------------------------
  logic np_req, msg_page, comply_ack, sent_toggle;
  logic [10:0] np_code;

  // writable fields; bit 14 and the toggle bit ignore writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      np_req <= NPT_NEXT_PAGE_RST;
      msg_page <= NPT_MSG_PAGE_RST;
      comply_ack <= NPT_COMPLY_RST;
      np_code <= NPT_CODE_RST;
    end else if (ce && wr_npt) begin
      np_req <= bus.wdata[NPT_NEXT_PAGE];
      msg_page <= bus.wdata[NPT_MSG_PAGE];
      comply_ack <= bus.wdata[NPT_COMPLY];
      np_code <= bus.wdata[NPT_CODE_W-1:0];
    end
  end

  // the toggle tracks the word just exchanged, so a stale write cannot
  // desynchronise the arbitration with the partner
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sent_toggle <= NPT_TOGGLE_RST;
    end else if (ce && ev.word_done) begin
      sent_toggle <= ~ev.word_toggle;
    end
  end

  // transmitter takes the flag with the code to pick the page format
  always_comb begin
    np_word.next_page_request = np_req;
    np_word.message_page_flag = msg_page;
    np_word.will_comply_ack = comply_ack;
    np_word.sent_toggle_bit = sent_toggle;
    np_word.code = np_code;
  end

  // ---------------------------------------------------------------------
  // latched-high status flags
  // ---------------------------------------------------------------------
  logic rx_err_latch, fc_latch, pol_latch, page_rx;
  logic next_rx_err, next_fc, next_pol, next_page_rx;

  // a set in the clearing cycle wins, so no event is ever lost
  assign next_rx_err = ev.rx_error | (rx_err_latch & ~rd_rec);
  assign next_fc = ev.false_carrier | (fc_latch & ~rd_fcc);
  assign next_pol = ev.polarity_inv | (pol_latch & ~rd_ten);
  assign next_page_rx = ev.page_rx | (page_rx & ~rd_exp);

  // one flop backs both the expansion bit and its summary copy
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_err_latch <= 1'b0;
      fc_latch <= 1'b0;
      pol_latch <= 1'b0;
      page_rx <= 1'b0;
    end else if (ce) begin
      rx_err_latch <= next_rx_err;
      fc_latch <= next_fc;
      pol_latch <= next_pol;
      page_rx <= next_page_rx;
    end
  end

  // ---------------------------------------------------------------------
  // latched-low signal detect and descrambler lock
  // ---------------------------------------------------------------------
  logic [LL_W-1:0] ll_src, ll_held;

  assign ll_src[LL_SIG_DETECT] = ev.sig_detect;
  assign ll_src[LL_DESCR_LOCK] = ev.descr_lock;

  // rearmed by a summary read, the only register that shows them
  psnp_ll_bits #(
    .N(LL_W)
  ) u_ll (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .src(ll_src),
    .rd_rearm(rd_sum),
    .held(ll_held)
  );

  // ---------------------------------------------------------------------
  // false carrier counter
  // ---------------------------------------------------------------------
  logic [FC_CNT_W-1:0] fc_count, next_fc_count;
  logic fc_at_max;

  // sticks at the top rather than wrap, so an overflow stays visible;
  // an event in the read cycle starts the new count at one
  assign fc_at_max = (fc_count == FC_CNT_MAX);
  assign next_fc_count =
    wr_fcc ? bus.wdata[FC_CNT_W-1:0] :
    rd_fcc ? {{(FC_CNT_W-1){1'b0}}, ev.false_carrier} :
    (ev.false_carrier && !fc_at_max) ? fc_count + 8'h01 :
    fc_count;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fc_count <= FC_CNT_RST;
    end else if (ce) begin
      fc_count <= next_fc_count;
    end
  end

  // ---------------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_evt, next_irq_stat;
  logic sig_drop;

  // a drop of signal detect while its latched-low copy is still high is the loss worth flagging
  assign sig_drop = ll_held[LL_SIG_DETECT] & ~ev.sig_detect;
  assign irq_evt[IRQ_RX_ERR] = ev.rx_error;
  assign irq_evt[IRQ_FALSE_CARR] = ev.false_carrier;
  assign irq_evt[IRQ_PAGE_RX] = ev.page_rx;
  assign irq_evt[IRQ_SIG_LOSS] = sig_drop;

  // write one to clear; a new event in that cycle keeps its bit
  assign next_irq_stat =
    irq_evt | (irq_stat & ~(wr_ist ? bus.wdata[IRQ_W-1:0] : 4'h0));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat <= 4'h0;
      irq_mask <= IRQ_MASK_RST;
    end else if (ce) begin
      irq_stat <= next_irq_stat;
      if (wr_imk) begin
        irq_mask <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ---------------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------------
  logic [15:0] v_exp, v_npt, v_sum, v_fcc, v_ten, v_ist, v_imk;
  logic [15:0] next_rdata;

  // expansion: only the next page ability and page received live here
  always_comb begin
    v_exp = 16'h0000;
    v_exp[EXP_NP_ABLE] = EXP_NP_ABLE_VAL;
    v_exp[EXP_PAGE_RX] = page_rx;
  end

  // next page word as software sees it; bit 14 reads zero
  always_comb begin
    v_npt = 16'h0000;
    v_npt[NPT_NEXT_PAGE] = np_req;
    v_npt[NPT_MSG_PAGE] = msg_page;
    v_npt[NPT_COMPLY] = comply_ack;
    v_npt[NPT_TOGGLE] = sent_toggle;
    v_npt[NPT_CODE_W-1:0] = np_code;
  end

  // summary: upper byte only, reserved top bits stay zero
  always_comb begin
    v_sum = 16'h0000;
    v_sum[SUM_RX_ERR] = rx_err_latch;
    v_sum[SUM_POLARITY] = pol_latch;
    v_sum[SUM_FALSE_CARR] = fc_latch;
    v_sum[SUM_SIG_DETECT] = ll_held[LL_SIG_DETECT];
    v_sum[SUM_DESCR_LOCK] = ll_held[LL_DESCR_LOCK];
    v_sum[SUM_PAGE_RX] = page_rx;
  end

  // false carrier counter, tenbase polarity and interrupt registers
  assign v_fcc = {8'h00, fc_count};
  always_comb begin
    v_ten = 16'h0000;
    v_ten[TEN_POLARITY] = pol_latch;
  end
  assign v_ist = {12'h000, irq_stat};
  assign v_imk = {12'h000, irq_mask};

  // the receive error count itself lives elsewhere, so it reads zero;
  // unmapped addresses read zero as well
  assign next_rdata =
    hit_exp ? v_exp :
    hit_npt ? v_npt :
    hit_sum ? v_sum :
    hit_fcc ? v_fcc :
    hit_ten ? v_ten :
    hit_ist ? v_ist :
    hit_imk ? v_imk :
    16'h0000;

  // data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= bus.rd ? next_rdata : 16'h0000;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_comply_write: assert property (
    (ce && wr_npt) |=> np_word.will_comply_ack == $past(bus.wdata[12]))
    else $error("comply bit did not take the written value");

  a_toggle_inverse: assert property (
    (ce && ev.word_done) |=>
      np_word.sent_toggle_bit == !$past(ev.word_toggle))
    else $error("sent toggle is not the inverse of the exchanged toggle");

  a_code_readback: assert property (
    (ce && wr_npt) ##1 (ce && bus.rd && hit_npt && !wr_npt) |=>
      rdata[10:0] == $past(bus.wdata[10:0], 2))
    else $error("code field read back differs from the write");

  a_msg_flag_out: assert property (
    (ce && wr_npt) |=>
      np_word.message_page_flag == $past(bus.wdata[13]))
    else $error("message page flag not driven to transmitter");

  a_summary_top_zero: assert property (
    (ce && rd_sum) |=> rdata[15:14] == 2'b00)
    else $error("reserved summary bits read nonzero");

  a_rx_err_hold: assert property (
    (ce && ev.rx_error) ##1 (ce && !rd_rec)[*3] |=> rx_err_latch)
    else $error("receive error flag lost before counter read");

  a_rx_err_clear: assert property (
    (ce && rd_rec && !ev.rx_error) |=> !rx_err_latch)
    else $error("receive error flag not cleared by counter read");

  a_pol_clear: assert property (
    (ce && rd_ten && !ev.polarity_inv) |=> !pol_latch)
    else $error("polarity copy not cleared by tenbase read");

  a_fc_latch_read: assert property (
    (ce && fc_latch && rd_sum && !rd_fcc) |=> fc_latch)
    else $error("false carrier flag cleared by wrong read");

  a_sig_low_hold: assert property (
    (ce && !ev.sig_detect) ##1 (ce && !rd_sum)[*2] |=>
      !ll_held[LL_SIG_DETECT])
    else $error("signal detect rose again before being read");

  a_lock_rearm: assert property (
    (ce && rd_sum) |=> ll_held[LL_DESCR_LOCK] == $past(ev.descr_lock))
    else $error("descrambler lock not rearmed by summary read");

  a_page_keep: assert property (
    (ce && page_rx && rd_sum && !rd_exp) |=> page_rx)
    else $error("page received cleared by summary read");

  a_page_clear: assert property (
    (ce && rd_exp && !ev.page_rx) |=> !page_rx)
    else $error("page received not cleared by expansion read");

  a_fc_count_step: assert property (
    (ce && ev.false_carrier && !rd_fcc && !wr_fcc) |=>
      fc_count == ($past(fc_count) == FC_CNT_MAX ? FC_CNT_MAX :
                   8'($past(fc_count) + 8'h01)))
    else $error("false carrier count did not step or saturate");

  a_rx_err_set: assert property (
    (ce && ev.rx_error) |=> rx_err_latch)
    else $error("receive error event did not set the flag");

  a_pol_sum_keep: assert property (
    (ce && pol_latch && rd_sum && !rd_ten) |=> pol_latch)
    else $error("polarity copy cleared by summary read");

  a_fc_latch_set: assert property (
    (ce && ev.false_carrier) |=> fc_latch)
    else $error("false carrier event did not set the flag");

  a_page_set: assert property (
    (ce && ev.page_rx) |=> page_rx)
    else $error("link code word did not set page received");

  a_fc_count_clear: assert property (
    (ce && rd_fcc && !wr_fcc && !ev.false_carrier) |=>
      fc_count == FC_CNT_RST)
    else $error("false carrier count not cleared by read");

endmodule : psnp_regs

// ---- inc/psnp_pkg.sv ----
// package: register map, field layout, reset values and carriers of the block
package psnp_pkg;

  // ---------------------------------------------------------------------
  // register offsets (5-bit management address)
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] OFS_AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] OFS_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] OFS_PHY_STATUS_SUMMARY = 5'h10;
  localparam logic [4:0] OFS_FALSE_CARRIER_CNT = 5'h14;
  localparam logic [4:0] OFS_RECEIVE_ERROR_CNT = 5'h15;
  localparam logic [4:0] OFS_TENBASE_STATUS = 5'h18;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h1c;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1d;

  // ---------------------------------------------------------------------
  // next page transmit fields
  // ---------------------------------------------------------------------
  localparam int unsigned NPT_NEXT_PAGE = 15;
  localparam int unsigned NPT_MSG_PAGE = 13;
  localparam int unsigned NPT_COMPLY = 12;
  localparam int unsigned NPT_TOGGLE = 11;
  localparam int unsigned NPT_CODE_W = 11;
  localparam logic NPT_NEXT_PAGE_RST = 1'b0;
  localparam logic NPT_MSG_PAGE_RST = 1'b1;
  localparam logic NPT_COMPLY_RST = 1'b0;
  localparam logic NPT_TOGGLE_RST = 1'b0;
  localparam logic [10:0] NPT_CODE_RST = 11'h001;

  // ---------------------------------------------------------------------
  // status summary fields (15:14 reserved, read as zero)
  // ---------------------------------------------------------------------
  localparam int unsigned SUM_RX_ERR = 13;
  localparam int unsigned SUM_POLARITY = 12;
  localparam int unsigned SUM_FALSE_CARR = 11;
  localparam int unsigned SUM_SIG_DETECT = 10;
  localparam int unsigned SUM_DESCR_LOCK = 9;
  localparam int unsigned SUM_PAGE_RX = 8;

  // expansion register, tenbase status and counter fields
  localparam int unsigned EXP_NP_ABLE = 2;
  localparam int unsigned EXP_PAGE_RX = 1;
  localparam logic EXP_NP_ABLE_VAL = 1'b1;
  localparam int unsigned TEN_POLARITY = 4;
  localparam int unsigned FC_CNT_W = 8;
  localparam logic [7:0] FC_CNT_MAX = 8'hff;
  localparam logic [7:0] FC_CNT_RST = 8'h00;

  // ---------------------------------------------------------------------
  // interrupt status / mask layout
  // ---------------------------------------------------------------------
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RX_ERR = 0;
  localparam int unsigned IRQ_FALSE_CARR = 1;
  localparam int unsigned IRQ_PAGE_RX = 2;
  localparam int unsigned IRQ_SIG_LOSS = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // latched-low bit slots
  localparam int unsigned LL_W = 2;
  localparam int unsigned LL_SIG_DETECT = 0;
  localparam int unsigned LL_DESCR_LOCK = 1;

  // management register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } psnp_bus_s;

  // events and levels from the receive and negotiation logic
  typedef struct packed {
    logic rx_error;
    logic false_carrier;
    logic polarity_inv;
    logic sig_detect;
    logic descr_lock;
    logic page_rx;
    logic word_done;
    logic word_toggle;
  } psnp_evt_s;

  // next page word fields handed to the negotiation transmitter
  typedef struct packed {
    logic next_page_request;
    logic message_page_flag;
    logic will_comply_ack;
    logic sent_toggle_bit;
    logic [10:0] code;
  } psnp_np_s;

endpackage : psnp_pkg

// ---- rtl/psnp_ll_bits.sv ----
// latched-low status bits: drop on source loss, rearm on software read
`timescale 1ns/1ps

module psnp_ll_bits
  import psnp_pkg::*;
#(
  parameter int unsigned N = 2
) (
  input wire logic clk, // core clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [N-1:0] src, // live source levels
  input wire logic rd_rearm, // read of the owning register
  output logic [N-1:0] held // latched-low value seen by software
);

  // ---------------------------------------------------------------------
  // one latch per bit
  // ---------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic next_held;
      // a read reloads the live level, otherwise a low sticks
      assign next_held = rd_rearm ? src[i] : (held[i] & src[i]);
      always_ff @(posedge clk) begin
        if (!nrst) begin
          held[i] <= 1'b0;
        end else if (ce) begin
          held[i] <= next_held;
        end
      end
    end
  endgenerate

endmodule : psnp_ll_bits

// ---- tb/testbench.sv ----
// self-checking testbench of the status summary and next page registers
`timescale 1ns/1ps

module testbench
  import psnp_pkg::*;
;
  logic clk;
  logic nrst;
  logic ce;
  psnp_bus_s bus;
  psnp_evt_s ev;
  logic [15:0] rdata;
  psnp_np_s np_word;
  logic irq;
  int num_errors;
  int total_checks;
  int seed;
  int n;
  logic [15:0] wd;
  logic tog;

  psnp_regs uut (
    .clk(clk), // core clock
    .nrst(nrst), // synchronous reset
    .ce(ce), // clock enable
    .bus(bus), // register port
    .rdata(rdata), // read data
    .ev(ev), // events and levels
    .np_word(np_word), // next page fields
    .irq(irq) // interrupt level
  );

  // ---------------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // a hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  // ---------------------------------------------------------------------
  // expectation functions and checking
  // ---------------------------------------------------------------------
  // register view of next page: bit 14 reserved, bit 11 from the toggle
  function automatic logic [15:0] npx(input logic [15:0] d, input logic t);
    return {d[15], 1'b0, d[13:12], t, d[10:0]};
  endfunction : npx

  // struct view of the same word, padded to 16 bits
  function automatic logic [15:0] npv(input logic [15:0] r);
    return {1'b0, r[15], r[13:0]};
  endfunction : npv

  task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] expd);
    total_checks++;
    if (seen !== expd) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, expd, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------
  // bus and event drivers
  // ---------------------------------------------------------------------
  // each strobe lasts one cycle; the next call waits an edge first
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input string what, input logic [4:0] a,
      input logic [15:0] expd);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(what, rdata, expd);
  endtask : rdchk

  // write then read back with no gap, as the master may do
  task automatic wrrd(input string what, input logic [4:0] a,
      input logic [15:0] d, input logic [15:0] expd);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(what, rdata, expd);
  endtask : wrrd

  // flips the masked event bits for cyc cycles, then flips them back
  task automatic evt(input logic [7:0] m, input int cyc);
    @(posedge clk);
    ev <= psnp_evt_s'(ev ^ m);
    repeat (cyc) @(posedge clk);
    ev <= psnp_evt_s'(ev ^ m);
    #1;
  endtask : evt

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 93621;
    num_errors = 0;
    total_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    bus = '0;
    ev = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("np_word reset", {1'b0, np_word}, 16'h2001);
    chk("irq reset", {15'h0000, irq}, 16'h0000);
    rdchk("next page reset", OFS_NEXT_PAGE_TRANSMIT, 16'h2001);
    rdchk("expansion reset", OFS_AUTONEG_EXPANSION, 16'h0004);
    rdchk("summary reset", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("fc count reset", OFS_FALSE_CARRIER_CNT, 16'h0000);
    rdchk("mask reset", OFS_IRQ_MASK, 16'h0000);
    // summary is read-only and its top bits stay zero
    wr(OFS_PHY_STATUS_SUMMARY, 16'hffff);
    rdchk("summary write", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("unmapped", 5'h1f, 16'h0000);
    @(posedge clk);
    #1;
    chk("rdata after read", rdata, 16'h0000);
    // next page: corners first, then random words and toggles
    for (int i = 0; i < 6; i++) begin
      wd = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      tog = 1'($random(seed));
      evt({6'h00, 1'b1, tog}, 1);
      wrrd("next page", OFS_NEXT_PAGE_TRANSMIT, wd, npx(wd, !tog));
      chk("np_word", {1'b0, np_word}, npv(npx(wd, !tog)));
    end
    // a strobe with the clock enable low must leave the register alone
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_NEXT_PAGE_TRANSMIT, ~wd);
    @(posedge clk);
    ce <= 1'b1;
    rdchk("ce low", OFS_NEXT_PAGE_TRANSMIT, npx(wd, !tog));
    // receive error latch, interrupt raise, mask and clear
    wr(OFS_IRQ_STATUS, 16'h000f);
    evt(8'h80, 1);
    rdchk("rx err latch", OFS_PHY_STATUS_SUMMARY, 16'h2000);
    rdchk("rx err kept", OFS_PHY_STATUS_SUMMARY, 16'h2000);
    rdchk("irq status", OFS_IRQ_STATUS, 16'h0001);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0001);
    chk("irq unmasked", {15'h0000, irq}, 16'h0001);
    rdchk("rx err count", OFS_RECEIVE_ERROR_CNT, 16'h0000);
    rdchk("rx err cleared", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    wr(OFS_IRQ_STATUS, 16'h0001);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    // false carrier: random burst, then saturation and write
    n = ($random(seed) & 7) + 1;
    evt(8'h40, n);
    rdchk("fc latch", OFS_PHY_STATUS_SUMMARY, 16'h0800);
    rdchk("fc count", OFS_FALSE_CARRIER_CNT, 16'(n));
    rdchk("fc latch clear", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("fc count clear", OFS_FALSE_CARRIER_CNT, 16'h0000);
    evt(8'h40, 300);
    rdchk("fc saturate", OFS_FALSE_CARRIER_CNT, 16'h00ff);
    wr(OFS_FALSE_CARRIER_CNT, 16'hff05);
    rdchk("fc write", OFS_FALSE_CARRIER_CNT, 16'h0005);
    rdchk("fc latch gone", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    // polarity copy survives summary reads, clears on tenbase read
    evt(8'h20, 2);
    rdchk("polarity", OFS_PHY_STATUS_SUMMARY, 16'h1000);
    rdchk("polarity kept", OFS_PHY_STATUS_SUMMARY, 16'h1000);
    rdchk("tenbase", OFS_TENBASE_STATUS, 16'h0010);
    rdchk("polarity clear", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("tenbase clear", OFS_TENBASE_STATUS, 16'h0000);
    // page received copy clears only through the expansion read
    evt(8'h04, 1);
    rdchk("page copy", OFS_PHY_STATUS_SUMMARY, 16'h0100);
    rdchk("page kept", OFS_PHY_STATUS_SUMMARY, 16'h0100);
    rdchk("expansion", OFS_AUTONEG_EXPANSION, 16'h0006);
    rdchk("page clear", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("expansion clear", OFS_AUTONEG_EXPANSION, 16'h0004);
    // latched-low bits follow the source only after a rearming read
    wr(OFS_IRQ_STATUS, 16'h000f);
    @(posedge clk);
    ev.sig_detect <= 1'b1;
    ev.descr_lock <= 1'b1;
    rdchk("ll not armed", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("ll live", OFS_PHY_STATUS_SUMMARY, 16'h0600);
    evt(8'h18, 1);
    rdchk("ll dropped", OFS_PHY_STATUS_SUMMARY, 16'h0000);
    rdchk("ll rearmed", OFS_PHY_STATUS_SUMMARY, 16'h0600);
    rdchk("sig loss irq", OFS_IRQ_STATUS, 16'h0008);
    summarize();
  end

endmodule : testbench
